/* File: common/flash_pkg.sv */
package flash_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CFG_OFS    = 8'h04;
    localparam logic [7:0] GEOM_OFS   = 8'h08;
    localparam logic [7:0] FRAMES_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // camera_control_reg bit positions
    localparam int RUN_BIT  = 0;
    localparam int XE_BIT   = 1;
    localparam int LED_BIT  = 2;
    localparam int FAST_BIT = 3;

    // Flash configuration fields
    localparam int FIRST_LSB  = 0;
    localparam int NUM_LSB    = 4;
    localparam int DELAY_LSB  = 8;
    localparam int LENGTH_LSB = 16;
    localparam int PHYS_LSB   = 0;
    localparam int DUMMY_LSB  = 16;

    // Reset values
    localparam logic [3:0]  CTRL_RST  = 4'h0;
    localparam logic [23:0] CFG_RST   = 24'h00_00_10;
    localparam logic [11:0] PHYS_RST  = 12'h400;
    localparam logic [11:0] DUMMY_RST = 12'h010;
    localparam logic [7:0]  NFR_RST   = 8'h00;

    // Flash frame count that means "every frame" / "forever"
    localparam logic [3:0] NUM_ALWAYS = 4'hF;

    // APB request bundle from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Xenon sequence states
    typedef enum logic [2:0] {
        X_IDLE  = 3'b000,
        X_RESET = 3'b001,
        X_DUMMY = 3'b010,
        X_READ  = 3'b011,
        X_DONE  = 3'b100
    } xe_state_t;

    // State of the sequencer top, apart from the line, delay and length counters
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [23:0] cfg;
        logic [11:0] phys;
        logic [11:0] dummy;
        logic [7:0]  nfr;
        xe_state_t   xs;
        logic [3:0]  frame_idx;
        logic [3:0]  fired;
        logic [7:0]  taken;
        logic        fire;
        logic        rec_b;
        logic        led_on;
        logic [3:0]  led_cnt;
        logic        led_prev;
        logic        line_rst;
        logic        strobe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } flash_state_t;

endpackage : flash_pkg

/* File: rtl/flash_strobe_sequencer.sv */
module flash_strobe_sequencer (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // APB slave
    input  wire flash_pkg::apb_req_t apb_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Readout sequencer events
    input  wire logic              line_tick_i,
    input  wire logic              frame_start_i,
    input  wire logic              record_change_i,
    input  wire logic              snapshot_mode_i,
    input  wire logic              last_line_reset_i,
    // Outputs
    output logic                   flash_strobe_o,
    output logic                   record_b_o,
    output logic                   line_reset_o
);

    flash_pkg::flash_state_t st;
    flash_pkg::flash_state_t next_st;

    // Field views
    logic              run;
    logic              xenon_flash_enable;
    logic              led_flash_enable;
    logic              fast_reset;
    logic [3:0]        first_frame;
    logic [3:0]        flash_num;
    logic [7:0]        flash_delay;
    logic [7:0]        flash_length;
    assign run                = st.ctrl[flash_pkg::RUN_BIT];
    assign xenon_flash_enable = st.ctrl[flash_pkg::XE_BIT];
    assign led_flash_enable   = st.ctrl[flash_pkg::LED_BIT];
    assign fast_reset         = st.ctrl[flash_pkg::FAST_BIT];
    assign first_frame        = st.cfg[flash_pkg::FIRST_LSB +: 4];
    assign flash_num          = st.cfg[flash_pkg::NUM_LSB +: 4];
    assign flash_delay        = st.cfg[flash_pkg::DELAY_LSB +: 8];
    assign flash_length       = st.cfg[flash_pkg::LENGTH_LSB +: 8];

    // Counter controls, sequence conditions and APB decodes
    logic              line_load;
    logic [11:0]       line_val;
    logic              line_step;
    logic              line_zero;
    logic              dly_zero;
    logic              len_zero;
    logic              timer_load;
    logic              dly_step;
    logic              len_step;
    logic              x_on;
    logic              enter_dummy;
    logic              xe_go;
    logic              led_restart;
    logic              setup;
    logic              wr;

    // ----------------------------------------------------------------
    // Line, delay and length counters
    // ----------------------------------------------------------------
    line_down_counter #(.W(12)) u_lines (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (line_load),
        .load_val_i (line_val),
        .step_i     (line_step),
        .count_o    (),
        .zero_o     (line_zero)
    );

    line_down_counter #(.W(8)) u_delay (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (timer_load),
        .load_val_i (flash_delay),
        .step_i     (dly_step),
        .count_o    (),
        .zero_o     (dly_zero)
    );

    line_down_counter #(.W(8)) u_length (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (timer_load),
        .load_val_i (flash_length),
        .step_i     (len_step),
        .count_o    (),
        .zero_o     (len_zero)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st     = st;
        setup       = apb_i.psel && !apb_i.penable;
        wr          = apb_i.psel && apb_i.penable && st.pready && apb_i.pwrite;
        xe_go       = run && xenon_flash_enable;
        line_load   = 1'b0;
        line_val    = st.dummy;
        line_step   = 1'b0;
        timer_load  = 1'b0;
        enter_dummy = 1'b0;
        x_on        = (st.xs == flash_pkg::X_DUMMY) && st.fire && dly_zero && !len_zero;
        // Both timers tick on line time only, so the dummy gap is never accelerated
        dly_step    = (st.xs == flash_pkg::X_DUMMY) && line_tick_i;
        len_step    = dly_step && dly_zero;

        // Register writes; the access phase is always one cycle
        if (wr) begin
            unique case (apb_i.paddr)
                flash_pkg::CTRL_OFS:   next_st.ctrl  = apb_i.pwdata[3:0];
                flash_pkg::CFG_OFS:    next_st.cfg   = apb_i.pwdata[23:0];
                flash_pkg::GEOM_OFS: begin
                    next_st.phys  = apb_i.pwdata[flash_pkg::PHYS_LSB +: 12];
                    next_st.dummy = apb_i.pwdata[flash_pkg::DUMMY_LSB +: 12];
                end
                flash_pkg::FRAMES_OFS: next_st.nfr   = apb_i.pwdata[7:0];
                default: ;
            endcase
        end

        // Read data and error are prepared in setup, shown in access
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
        if (setup) begin
            unique case (apb_i.paddr)
                flash_pkg::CTRL_OFS:   next_st.prdata = {28'h0, st.ctrl};
                flash_pkg::CFG_OFS:    next_st.prdata = {8'h0, st.cfg};
                flash_pkg::GEOM_OFS:   next_st.prdata = {4'h0, st.dummy, 4'h0, st.phys};
                flash_pkg::FRAMES_OFS: next_st.prdata = {24'h0, st.nfr};
                flash_pkg::STATUS_OFS: next_st.prdata = {8'h0, st.taken, st.fired,
                                           st.frame_idx, 1'b0, st.xs, st.rec_b,
                                           st.led_on, st.fire, st.strobe};
                default:               next_st.pslverr = 1'b1;
            endcase
        end

        // Xenon sequence
        unique case (st.xs)
            flash_pkg::X_IDLE: begin
                if (xe_go && snapshot_mode_i) begin
                    next_st.xs        = flash_pkg::X_RESET;
                    next_st.frame_idx = 4'h0;
                    next_st.fired     = 4'h0;
                    next_st.taken     = 8'h00;
                    line_load         = 1'b1;
                    line_val          = st.phys;
                end
            end
            flash_pkg::X_RESET: begin
                line_step = !line_zero && (fast_reset || line_tick_i);
                if (line_zero) begin
                    enter_dummy = 1'b1;
                end
            end
            flash_pkg::X_DUMMY: begin
                line_step = line_tick_i;
                if (line_zero) begin
                    next_st.fire  = 1'b0;
                    next_st.taken = st.taken + 8'h01;
                    if (st.frame_idx != 4'hF) begin
                        next_st.frame_idx = st.frame_idx + 4'h1;
                    end
                    // stop after programmed frames; zero means no limit
                    if (st.nfr != 8'h00 && st.taken + 8'h01 >= st.nfr) begin
                        next_st.xs = flash_pkg::X_DONE;
                    end else begin
                        next_st.xs = flash_pkg::X_READ;
                    end
                end
            end
            flash_pkg::X_READ: begin
                if (last_line_reset_i) begin
                    enter_dummy = 1'b1;
                end
            end
            flash_pkg::X_DONE: ;
            default: next_st.xs = flash_pkg::X_IDLE;
        endcase

        // Dummy period set-up: timers and the per-frame fire decision
        if (enter_dummy) begin
            next_st.xs = flash_pkg::X_DUMMY;
            line_load  = 1'b1;
            line_val   = st.dummy;
            timer_load = 1'b1;
            next_st.fire = (st.frame_idx >= first_frame) &&
                           (flash_num == flash_pkg::NUM_ALWAYS || st.fired < flash_num);
            if (next_st.fire && st.fired != 4'hF) begin
                next_st.fired = st.fired + 4'h1;
            end
        end

        // enable or run cleared aborts the sequence
        if (!xe_go) begin
            next_st.xs   = flash_pkg::X_IDLE;
            next_st.fire = 1'b0;
        end

        // record B at trigger, held for the sequence
        if (x_on && xe_go) begin
            next_st.rec_b = 1'b1;
        end else if (next_st.xs == flash_pkg::X_IDLE) begin
            next_st.rec_b = 1'b0;
        end

        // LED restart on run-and-enable rising, so a late run still lights it
        next_st.led_prev = run && led_flash_enable;
        led_restart      = (run && led_flash_enable && !st.led_prev) || record_change_i;
        if (!(run && led_flash_enable)) begin
            next_st.led_on = 1'b0;
        end else if (led_restart) begin
            next_st.led_on  = 1'b1;
            next_st.led_cnt = 4'h0;
        end else if (st.led_on && frame_start_i && flash_num != flash_pkg::NUM_ALWAYS) begin
            next_st.led_cnt = st.led_cnt + 4'h1;
            if (st.led_cnt + 4'h1 >= flash_num) begin
                next_st.led_on = 1'b0;
            end
        end

        // clocked strobe from both sources; one cycle after the counters
        next_st.strobe   = (x_on && xe_go) || next_st.led_on;
        next_st.line_rst = line_step && (st.xs == flash_pkg::X_RESET);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st       <= '0;
            st.ctrl  <= flash_pkg::CTRL_RST;
            st.cfg   <= flash_pkg::CFG_RST;
            st.phys  <= flash_pkg::PHYS_RST;
            st.dummy <= flash_pkg::DUMMY_RST;
            st.nfr   <= flash_pkg::NFR_RST;
            st.xs    <= flash_pkg::X_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign prdata_o       = st.prdata;
    assign pready_o       = st.pready;
    assign pslverr_o      = st.pslverr;
    assign flash_strobe_o = st.strobe;
    assign record_b_o     = st.rec_b;
    assign line_reset_o   = st.line_rst;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_start;
        st.xs == flash_pkg::X_IDLE ##1 st.xs == flash_pkg::X_RESET;
    endsequence

    sequence seq_reset_end;
        st.xs == flash_pkg::X_RESET ##1 st.xs == flash_pkg::X_DUMMY;
    endsequence

    snap_gate_a: assert property (seq_start |-> $past(snapshot_mode_i))
        else $error("xenon started outside snapshot mode");

    start_cond_a: assert property (seq_start |-> $past(run && xenon_flash_enable))
        else $error("xenon started without enable and run");

    reset_first_a: assert property (seq_reset_end |-> $past(line_zero))
        else $error("dummy period entered before all lines reset");

    fast_reset_a: assert property ((st.xs == flash_pkg::X_RESET && fast_reset && xe_go
        && !line_zero) |=> line_reset_o)
        else $error("fast reset missed a clock");

    first_frame_a: assert property ((enter_dummy && st.frame_idx < first_frame)
        |=> !st.fire)
        else $error("strobe armed before first flash frame");

    abort_a: assert property (!xe_go |=> st.xs == flash_pkg::X_IDLE)
        else $error("xenon sequence kept running after abort");

    delay_hold_a: assert property ((st.xs == flash_pkg::X_DUMMY && !dly_zero
        && !led_flash_enable) |=> !flash_strobe_o)
        else $error("strobe before flash delay elapsed");

    length_end_a: assert property ((x_on && xe_go && !next_st.led_on) ##1 len_zero
        |=> !flash_strobe_o)
        else $error("strobe outlived flash length");

    record_b_a: assert property ((x_on && xe_go) |=> record_b_o [*2])
        else $error("no record B at trigger");

    led_on_a: assert property ((run && led_flash_enable && !st.led_prev)
        |=> ##1 flash_strobe_o)
        else $error("led strobe not raised");

    led_forever_a: assert property ((st.led_on && run && led_flash_enable
        && flash_num == flash_pkg::NUM_ALWAYS) |=> st.led_on)
        else $error("endless led strobe dropped");

endmodule : flash_strobe_sequencer

/* File: rtl/line_down_counter.sv */
// Loadable down counter that stops at zero; load wins over step
module line_down_counter #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         step_i,
    // State
    output logic [W-1:0]      count_o,
    output logic              zero_o
);

    logic [W-1:0] next_count;

    // Next count
    always_comb begin
        next_count = count_o;
        if (load_i) begin
            next_count = load_val_i;
        end else if (step_i && count_o != '0) begin
            next_count = count_o - W'(1);
        end
    end

    // Count register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end

    assign zero_o = (count_o == '0);

endmodule : line_down_counter

/* File: tb/flash_driver_model.sv */
module flash_driver_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Lines seen at the lamp driver
    input  wire logic        strobe_i,
    input  wire logic        tick_i,
    input  wire logic        mark_i,
    input  wire logic        frm_i,
    input  wire logic        rec_b_i,
    input  wire logic        clr_i,
    // Measurements
    output logic [31:0]      pulses_o,
    output logic [31:0]      width_o,
    output logic [31:0]      delay_o,
    output logic [31:0]      marks_o,
    output logic             rec_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        prev;
    logic [31:0] since;

    // ----------------------------------------------------------------
    // Lamp timing, measured in line ticks
    // ----------------------------------------------------------------
    // Ticks are counted from the last line reset, the lamp's time base
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {prev, since, pulses_o, width_o, delay_o, marks_o, rec_o} <= '0;
        end else if (clr_i) begin
            {since, pulses_o, width_o, delay_o, marks_o, rec_o} <= '0;
        end else begin
            prev <= strobe_i;
            if (mark_i || frm_i) begin
                since <= 32'h0;
            end else if (tick_i && !strobe_i) begin
                since <= since + 32'h1;
            end
            if (mark_i) begin
                marks_o <= marks_o + 32'h1;
            end
            if (tick_i && strobe_i) begin
                width_o <= width_o + 32'h1;
            end
            // A new flash: latch delay and record state at ignition
            if (strobe_i && !prev) begin
                pulses_o <= pulses_o + 32'h1;
                delay_o  <= since;
                rec_o    <= rec_b_i;
                width_o  <= 32'h0;
            end
        end
    end
endmodule : flash_driver_model

/* File: tb/flash_strobe_sequencer_tb.sv */
module flash_strobe_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } row_t;

    logic                clk = 1'h0;
    logic                rst_n = 1'h0;
    flash_pkg::apb_req_t apb = '0;
    logic [31:0]         prdata;
    logic                pready, pslverr, strobe, rec_b, lrst;
    logic                tick = 1'h0, fstart = 1'h0, rchg = 1'h0;
    logic                snap = 1'h0, llr = 1'h0, clr = 1'h0;
    logic [1:0]          tcnt = 2'h0;
    logic [31:0]         pulses, width, delay, marks, rd_v;
    logic                rec;
    int                  bad_count = 0;
    int                  checked = 0;
    row_t                rows [10];

    flash_strobe_sequencer dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .line_tick_i(tick),
        .frame_start_i(fstart), .record_change_i(rchg), .snapshot_mode_i(snap),
        .last_line_reset_i(llr), .flash_strobe_o(strobe), .record_b_o(rec_b),
        .line_reset_o(lrst)
    );

    flash_driver_model lamp (
        .clk_i(clk), .rst_n_i(rst_n), .strobe_i(strobe), .tick_i(tick),
        .mark_i(lrst), .frm_i(llr), .rec_b_i(rec_b), .clr_i(clr),
        .pulses_o(pulses), .width_o(width), .delay_o(delay), .marks_o(marks),
        .rec_o(rec)
    );

    // ----------------------------------------------------------------
    // Clock, line ticks and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end

    // One tick every four clocks keeps frames short
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    // Whole run is about a thousand cycles; this bound is far above it
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Called just after a rising edge; returns one idle edge later
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] r, output logic e);
        int n;
        n = 0;
        apb <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 20);
        r = prdata;
        e = pslverr;
        apb <= '0;
        if (n >= 20) chk(32'h0, 32'h1);
        @(posedge clk);
    endtask : apb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'h1, a, d, r, e);
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic pulse_clr();
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        @(posedge clk);
    endtask : pulse_clr

    task automatic fs();
        fstart <= 1'h1;
        @(posedge clk);
        fstart <= 1'h0;
        cyc(2);
    endtask : fs

    // Later frames start their dummy period at the last-line mark
    task automatic next_frame();
        llr <= 1'h1;
        @(posedge clk);
        llr <= 1'h0;
        cyc(60);
    endtask : next_frame

    task automatic end_of_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic e;
        // Reset values, write-back, read-only and unmapped places
        rows[0] = '{1'h0, flash_pkg::CTRL_OFS, 32'h0, 32'h0, 1'h0};
        rows[1] = '{1'h0, flash_pkg::CFG_OFS, 32'h0, 32'h10, 1'h0};
        rows[2] = '{1'h0, flash_pkg::GEOM_OFS, 32'h0, 32'h0010_0400, 1'h0};
        rows[3] = '{1'h0, flash_pkg::FRAMES_OFS, 32'h0, 32'h0, 1'h0};
        // Count 1 is nonzero; delay 2 plus length 3 stays below 8 dummies
        // software settings
        rows[4] = '{1'h1, flash_pkg::CFG_OFS, 32'hAB03_0210, 32'h0003_0210, 1'h0};
        // exposure is outside this block, frames are kept tiny
        rows[5] = '{1'h1, flash_pkg::GEOM_OFS, 32'hF008_F004, 32'h0008_0004, 1'h0};
        rows[6] = '{1'h1, flash_pkg::FRAMES_OFS, 32'h0000_0103, 32'h3, 1'h0};
        rows[7] = '{1'h1, flash_pkg::STATUS_OFS, 32'hFFFF_FFFF, 32'h0, 1'h0};
        rows[8] = '{1'h1, 8'h14, 32'h1, 32'h0, 1'h1};
        rows[9] = '{1'h0, 8'h1C, 32'h0, 32'h0, 1'h1};
        cyc(6);
        rst_n <= 1'h1;
        @(posedge clk);
        chk(32'(strobe), 32'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
            apb_xfer(1'h0, rows[i].addr, 32'h0, rd_v, e);
            if (!rows[i].err) chk(rd_v, rows[i].exp);
            chk(32'(e), 32'(rows[i].err));
        end
        // Xenon start gating, then a normal sequence
        wr(flash_pkg::CTRL_OFS, 32'h3);
        cyc(40);
        chk(marks, 32'h0);
        wr(flash_pkg::CTRL_OFS, 32'h2);
        snap <= 1'h1;
        cyc(40);
        chk(marks, 32'h0);
        chk(32'(rec_b), 32'h0);
        wr(flash_pkg::CTRL_OFS, 32'h3);
        cyc(80);
        chk(marks, 32'h4);
        chk(pulses, 32'h1);
        chk(delay, 32'h2);
        chk(width, 32'h3);
        chk(32'(rec), 32'h1);
        wr(flash_pkg::CTRL_OFS, 32'h0);
        pulse_clr();
        // Accelerated reset, dummy lines still at nominal rate
        wr(flash_pkg::CTRL_OFS, 32'hB);
        cyc(8);
        chk(marks, 32'h4);
        cyc(60);
        chk(delay, 32'h2);
        chk(width, 32'h3);
        wr(flash_pkg::CTRL_OFS, 32'h0);
        // First flash in frame 1 only
        wr(flash_pkg::FRAMES_OFS, 32'h0);
        wr(flash_pkg::CFG_OFS, 32'h0003_0211);
        pulse_clr();
        wr(flash_pkg::CTRL_OFS, 32'h3);
        cyc(80);
        chk(pulses, 32'h0);
        next_frame();
        chk(pulses, 32'h1);
        next_frame();
        chk(pulses, 32'h1);
        wr(flash_pkg::CTRL_OFS, 32'h0);
        // Every frame until the frame total is reached
        wr(flash_pkg::FRAMES_OFS, 32'h3);
        wr(flash_pkg::CFG_OFS, 32'h0003_02F0);
        pulse_clr();
        wr(flash_pkg::CTRL_OFS, 32'h3);
        cyc(80);
        repeat (3) next_frame();
        chk(pulses, 32'h3);
        apb_xfer(1'h0, flash_pkg::STATUS_OFS, 32'h0, rd_v, e);
        chk({29'h0, rd_v[6:4]}, 32'h4);
        wr(flash_pkg::CTRL_OFS, 32'h0);
        // LED flash: run gating, frame count and restarts
        snap <= 1'h0;
        wr(flash_pkg::CFG_OFS, 32'h0003_0220);
        wr(flash_pkg::CTRL_OFS, 32'h4);
        cyc(5);
        chk(32'(strobe), 32'h0);
        wr(flash_pkg::CTRL_OFS, 32'h5);
        cyc(3);
        chk(32'(strobe), 32'h1);
        fs();
        chk(32'(strobe), 32'h1);
        rchg <= 1'h1;
        @(posedge clk);
        rchg <= 1'h0;
        fs();
        chk(32'(strobe), 32'h1);
        fs();
        chk(32'(strobe), 32'h0);
        wr(flash_pkg::CTRL_OFS, 32'h1);
        wr(flash_pkg::CTRL_OFS, 32'h5);
        cyc(3);
        chk(32'(strobe), 32'h1);
        // Count fifteen holds the LED until the enable drops
        wr(flash_pkg::CFG_OFS, 32'h0003_02F0);
        wr(flash_pkg::CTRL_OFS, 32'h1);
        wr(flash_pkg::CTRL_OFS, 32'h5);
        repeat (20) fs();
        chk(32'(strobe), 32'h1);
        wr(flash_pkg::CTRL_OFS, 32'h1);
        cyc(3);
        chk(32'(strobe), 32'h0);
        // Reset in mid-run drops the strobe and clears control
        wr(flash_pkg::CTRL_OFS, 32'h5);
        cyc(3);
        rst_n <= 1'h0;
        @(posedge clk);
        chk(32'(strobe), 32'h0);
        cyc(3);
        rst_n <= 1'h1;
        @(posedge clk);
        apb_xfer(1'h0, flash_pkg::CTRL_OFS, 32'h0, rd_v, e);
        chk(rd_v, 32'h0);
        chk(32'(strobe), 32'h0);
        end_of_test();
    end
endmodule : flash_strobe_sequencer_tb
